// ===== bus_signal_cfg.svh
`ifndef BUS_SIGNAL_CFG_SVH
`define BUS_SIGNAL_CFG_SVH
// Overview of operation
// - Address-enable flag is high for the whole of every DMA cycle.
// - Address-enable flag is also high during refresh cycles this device starts.
// - Both outputs float in reset, then drive low, and low in power-on suspend.
// - Latch strobe marks system address, upper address and byte-high enable valid.
// - Latch strobe stays high through whole DMA and external master cycles.
// - Channel check raises an interrupt request only while generation is enabled.
`define SYNC_STAGES 2
`define NMI_RESET 1'b0
`define GPI_RESET 1'b0
`endif

// ===== bus_signal_pkg.sv
package bus_signal_pkg;
   typedef enum logic [1:0] {
      ST_RESET = 2'b00,
      ST_IDLE = 2'b01,
      ST_ACTIVE = 2'b10,
      ST_SUSPEND = 2'b11
   } drive_state_t;
endpackage

// ===== legacy_bus_cycle_signaling.sv
`timescale 1ns/1ns
`include "bus_signal_cfg.svh"
module legacy_bus_cycle_signaling (
   // Clock and reset.
   input wire logic clk,
   input wire logic arst_n,
   // Cycle indications from the bus sequencer.
   input wire logic dma_cycle,
   input wire logic refresh_cycle,
   input wire logic master_cycle,
   input wire logic addr_valid,
   input wire logic power_on_suspend,
   // Error input and controls.
   input wire logic channel_check_n,
   input wire logic nmi_enable,
   input wire logic reduced_io_bus_option,
   input wire logic nmi_clear,
   // Bus outputs with enables.
   output logic addr_enable_dma_flag,
   output logic addr_enable_dma_flag_oe,
   output logic addr_latch_strobe,
   output logic addr_latch_strobe_oe,
   output bus_signal_pkg::drive_state_t drive_state,
   // Processor side.
   output logic nmi_request,
   output logic general_input_zero
);
   import bus_signal_pkg::*;

   logic [`SYNC_STAGES-1:0] chk_sync;
   logic chk_active;
   logic next_aen;
   logic next_ale;

   // ----------------------------------------------------------------
   // Cycle decoding
   // ----------------------------------------------------------------
   // Suspend overrides every cycle indication, so both bus outputs pass through this gate.
   function automatic logic gate_by_suspend(input logic suspend, input logic cycle_hit);
      return !suspend && cycle_hit;
   endfunction

   // ----------------------------------------------------------------
   // Drive state
   // ----------------------------------------------------------------
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         drive_state <= ST_RESET;
      end else if (power_on_suspend) begin
         drive_state <= ST_SUSPEND;
      end else if (dma_cycle || refresh_cycle || master_cycle || addr_valid) begin
         drive_state <= ST_ACTIVE;
      end else begin
         drive_state <= ST_IDLE;
      end
   end

   // ----------------------------------------------------------------
   // Address enable and latch strobe
   // ----------------------------------------------------------------
   always_comb begin
      next_aen = gate_by_suspend(power_on_suspend, dma_cycle || refresh_cycle);
      next_ale = gate_by_suspend(power_on_suspend,
         addr_valid || dma_cycle || master_cycle);
   end

   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         // Both pins float while reset holds, as their enables are low.
         addr_enable_dma_flag <= 1'b0;
         addr_enable_dma_flag_oe <= 1'b0;
         addr_latch_strobe <= 1'b0;
         addr_latch_strobe_oe <= 1'b0;
      end else begin
         addr_enable_dma_flag <= next_aen;
         addr_enable_dma_flag_oe <= 1'b1;
         addr_latch_strobe <= next_ale;
         addr_latch_strobe_oe <= 1'b1;
      end
   end

   // ----------------------------------------------------------------
   // Channel check
   // ----------------------------------------------------------------
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         // The idle-high reset value keeps a false event from following reset.
         chk_sync <= '1;
      end else begin
         chk_sync <= {chk_sync[`SYNC_STAGES-2:0], channel_check_n};
      end
   end

   assign chk_active = !chk_sync[`SYNC_STAGES-1];

   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         nmi_request <= `NMI_RESET;
      end else if (chk_active && nmi_enable && !reduced_io_bus_option) begin
         // The event is tested first, so it wins over a clear in the same cycle.
         nmi_request <= 1'b1;
      end else if (nmi_clear) begin
         nmi_request <= 1'b0;
      end
   end

   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         general_input_zero <= `GPI_RESET;
      end else begin
         // Outside the reduced option the pin is an error source only.
         general_input_zero <= reduced_io_bus_option ? chk_sync[`SYNC_STAGES-1] : 1'b0;
      end
   end

   // ----------------------------------------------------------------
   // Checks
   // ----------------------------------------------------------------
   // All checks are cut off while reset holds, as the pins float then.
   a_dma_aen_high: assert property (@(posedge clk) disable iff (!arst_n)
      dma_cycle && !power_on_suspend
      |=> addr_enable_dma_flag)
      else $error("address enable low in DMA cycle");

   a_refresh_aen_high: assert property (@(posedge clk) disable iff (!arst_n)
      refresh_cycle && !power_on_suspend
      |=> addr_enable_dma_flag)
      else $error("address enable low in refresh cycle");

   a_quiet_aen_low: assert property (@(posedge clk) disable iff (!arst_n)
      !dma_cycle && !refresh_cycle
      |=> !addr_enable_dma_flag)
      else $error("address enable high outside DMA and refresh");

   a_outputs_driven: assert property (@(posedge clk) disable iff (!arst_n)
      1'b1
      |=> addr_enable_dma_flag_oe && addr_latch_strobe_oe)
      else $error("bus outputs not driven after reset");

   a_suspend_low: assert property (@(posedge clk) disable iff (!arst_n)
      power_on_suspend
      |=> !addr_enable_dma_flag && !addr_latch_strobe && addr_latch_strobe_oe)
      else $error("outputs not low in suspend");

   a_state_suspend: assert property (@(posedge clk) disable iff (!arst_n)
      power_on_suspend
      |=> drive_state == ST_SUSPEND)
      else $error("drive state not suspend");

   a_state_active: assert property (@(posedge clk) disable iff (!arst_n)
      !power_on_suspend && (dma_cycle || refresh_cycle || master_cycle || addr_valid)
      |=> drive_state == ST_ACTIVE)
      else $error("drive state not active in a cycle");

   a_state_idle: assert property (@(posedge clk) disable iff (!arst_n)
      !power_on_suspend && !(dma_cycle || refresh_cycle || master_cycle || addr_valid)
      |=> drive_state == ST_IDLE)
      else $error("drive state not idle between cycles");

   a_valid_strobe: assert property (@(posedge clk) disable iff (!arst_n)
      addr_valid && !power_on_suspend
      |=> addr_latch_strobe)
      else $error("strobe missing for valid address");

   a_quiet_strobe_low: assert property (@(posedge clk) disable iff (!arst_n)
      !addr_valid && !dma_cycle && !master_cycle
      |=> !addr_latch_strobe)
      else $error("strobe high with no valid address");

   a_dma_strobe: assert property (@(posedge clk) disable iff (!arst_n)
      dma_cycle && !power_on_suspend
      |=> addr_latch_strobe)
      else $error("strobe dropped in DMA cycle");

   a_master_strobe: assert property (@(posedge clk) disable iff (!arst_n)
      (master_cycle && !power_on_suspend)[*2]
      |=> addr_latch_strobe)
      else $error("strobe dropped in master cycle");

   a_sync_latency: assert property (@(posedge clk) disable iff (!arst_n)
      !channel_check_n
      |-> ##2 chk_active)
      else $error("channel check not seen two cycles later");

   a_nmi_raise: assert property (@(posedge clk) disable iff (!arst_n)
      !channel_check_n && nmi_enable && !reduced_io_bus_option
      ##1 nmi_enable && !reduced_io_bus_option
      ##1 nmi_enable && !reduced_io_bus_option |=> nmi_request)
      else $error("no interrupt request on channel check");

   a_nmi_set: assert property (@(posedge clk) disable iff (!arst_n)
      chk_active && nmi_enable && !reduced_io_bus_option
      |=> nmi_request)
      else $error("channel check event not latched");

   a_nmi_gated: assert property (@(posedge clk) disable iff (!arst_n)
      !nmi_request && (!nmi_enable || reduced_io_bus_option)
      |=> !nmi_request)
      else $error("interrupt request while disabled");

   a_nmi_pending: assert property (@(posedge clk) disable iff (!arst_n)
      nmi_request && !nmi_clear
      |=> nmi_request)
      else $error("interrupt request dropped without clear");

   a_nmi_clear: assert property (@(posedge clk) disable iff (!arst_n)
      nmi_clear && !(chk_active && nmi_enable && !reduced_io_bus_option)
      |=> !nmi_request)
      else $error("interrupt request not cleared");

   a_gpi_high: assert property (@(posedge clk) disable iff (!arst_n)
      reduced_io_bus_option && chk_sync[`SYNC_STAGES-1]
      |=> general_input_zero)
      else $error("general input low with pin high");

   a_gpi_low: assert property (@(posedge clk) disable iff (!arst_n)
      reduced_io_bus_option && !chk_sync[`SYNC_STAGES-1]
      |=> !general_input_zero)
      else $error("general input high with pin low");

   a_gpi_off: assert property (@(posedge clk) disable iff (!arst_n)
      !reduced_io_bus_option
      |=> !general_input_zero)
      else $error("general input set outside reduced option");

endmodule

// ===== slave_card.sv
`timescale 1ns/1ns
module slave_card (
   // Error report and I/O command from the card's own side.
   input wire logic report,
   input wire logic io_command,
   input wire logic [6:0] latchable_upper_addr,
   // Bus signals from the bridge.
   input wire logic addr_enable_dma_flag,
   input wire logic addr_latch_strobe,
   // Pin toward the bridge.
   output logic channel_check_n,
   // What the card made of the bus.
   output logic io_answer,
   output logic [6:0] captured_upper
);
   // The card drives the pin high itself, so it reads high whenever the card does not report.
   assign channel_check_n = report ? 1'b0 : 1'b1;
   // The card answers an I/O command only while the address enable flag is low.
   assign io_answer = io_command && !addr_enable_dma_flag;
   // The upper address is taken on the falling edge of the latch strobe.
   always @(negedge addr_latch_strobe) begin
      captured_upper <= latchable_upper_addr;
   end
endmodule

// ===== legacy_bus_cycle_signaling_tb.sv
`timescale 1ns/1ns
module legacy_bus_cycle_signaling_tb;
   import bus_signal_pkg::*;
   logic clk, arst_n, dma, rfr, mst, valid, susp, en, red, clr, report, chk_n;
   logic flag, flag_oe, strobe, strobe_oe, nmi, gpi;
   logic io_cmd, io_ans;
   logic [6:0] upper, captured;
   drive_state_t drive_state;
   int err_total = 0;
   int cmp_count = 0;
   int cycles = 0;
   legacy_bus_cycle_signaling u_dut (.clk(clk), .arst_n(arst_n), .dma_cycle(dma),
      .refresh_cycle(rfr), .master_cycle(mst), .addr_valid(valid), .power_on_suspend(susp),
      .channel_check_n(chk_n), .nmi_enable(en), .reduced_io_bus_option(red), .nmi_clear(clr),
      .addr_enable_dma_flag(flag), .addr_enable_dma_flag_oe(flag_oe),
      .addr_latch_strobe(strobe), .addr_latch_strobe_oe(strobe_oe),
      .drive_state(drive_state), .nmi_request(nmi), .general_input_zero(gpi));
   slave_card u_card (.report(report), .io_command(io_cmd), .latchable_upper_addr(upper),
      .addr_enable_dma_flag(flag), .addr_latch_strobe(strobe), .channel_check_n(chk_n),
      .io_answer(io_ans), .captured_upper(captured));
   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end
   always @(posedge clk) begin
      cycles++;
      if (cycles == 2000) begin
         err_total++;
         print_verdict();
      end
   end
   // ----------------------------------------
   // Shared tasks.
   // ----------------------------------------
   task automatic check(input logic [3:0] seen, input logic [3:0] exp);
      cmp_count++;
      if (seen !== exp) begin
         err_total++;
         $display("BAD %0t seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic step(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask
   task automatic run_cycle(input logic [4:0] in, input logic [1:0] exp, input drive_state_t st);
      {susp, dma, rfr, mst, valid} = in;
      repeat (3) begin
         step(1);
         check({flag_oe, strobe_oe, flag, strobe}, {2'b11, exp});
         check({2'b00, drive_state}, {2'b00, st});
      end
   endtask
   task automatic run_nmi();
      en = 1'b1;
      report = 1'b1;
      step(3);
      check({2'b00, nmi, gpi}, 4'h2);
      report = 1'b0;
      step(3);
      check({3'b000, nmi}, 4'h1);
      clr = 1'b1;
      step(1);
      clr = 1'b0;
      check({3'b000, nmi}, 4'h0);
      en = 1'b0;
      report = 1'b1;
      step(4);
      check({3'b000, nmi}, 4'h0);
      report = 1'b0;
      step(3);
   endtask
   task automatic run_reduced();
      red = 1'b1;
      en = 1'b1;
      report = 1'b1;
      step(3);
      check({2'b00, nmi, gpi}, 4'h0);
      report = 1'b0;
      step(3);
      check({2'b00, nmi, gpi}, 4'h1);
   endtask
   task automatic run_slave();
      upper = 7'h2A;
      valid = 1'b1;
      step(1);
      upper = 7'h55;
      step(1);
      valid = 1'b0;
      step(1);
      check({1'b0, captured[6:4]}, 4'h5);
      check(captured[3:0], 4'h5);
      io_cmd = 1'b1;
      dma = 1'b1;
      step(1);
      check({3'b000, io_ans}, 4'h0);
      dma = 1'b0;
      step(1);
      check({3'b000, io_ans}, 4'h1);
      io_cmd = 1'b0;
   endtask
   task automatic run_reset();
      dma = 1'b1;
      arst_n = 1'b0;
      step(1);
      check({flag_oe, strobe_oe, flag, strobe}, 4'h0);
      check({2'b00, drive_state}, {2'b00, ST_RESET});
      arst_n = 1'b1;
      step(1);
      check({flag_oe, strobe_oe, flag, strobe}, 4'hF);
      check({2'b00, drive_state}, {2'b00, ST_ACTIVE});
      dma = 1'b0;
      step(1);
      check({flag_oe, strobe_oe, flag, strobe}, 4'hC);
   endtask
   task print_verdict();
      $display("comparisons %0d mismatches %0d", cmp_count, err_total);
      if (err_total == 0 && cmp_count > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask
   initial begin
      {arst_n, dma, rfr, mst, valid, susp, en, red, clr, report} = '0;
      {io_cmd, upper} = '0;
      step(3);
      check({flag_oe, strobe_oe, flag, strobe}, 4'h0);
      check({2'b00, drive_state}, {2'b00, ST_RESET});
      arst_n = 1'b1;
      step(1);
      check({flag_oe, strobe_oe, flag, strobe}, 4'hC);
      check({2'b00, drive_state}, {2'b00, ST_IDLE});
      run_cycle(5'b01000, 2'b11, ST_ACTIVE);
      run_cycle(5'b00100, 2'b10, ST_ACTIVE);
      run_cycle(5'b00010, 2'b01, ST_ACTIVE);
      run_cycle(5'b00001, 2'b01, ST_ACTIVE);
      run_cycle(5'b11011, 2'b00, ST_SUSPEND);
      run_cycle(5'b00000, 2'b00, ST_IDLE);
      run_slave();
      run_nmi();
      run_reduced();
      run_reset();
      print_verdict();
   end
endmodule
